// >>> rtl/lpddr2_ref_cfg.svh
// timing constants for the refresh and self-refresh controller
`ifndef LPDDR2_REF_CFG_SVH
`define LPDDR2_REF_CFG_SVH
`define CLK_PERIOD_NS 50
`define TREFW_MS 32
`define REF_PER_WINDOW 4096
`define TREFI_NS 7800
`define TREFI_CYC ((`TREFI_NS) / (`CLK_PERIOD_NS))
`define TRFCAB_NS 130
`define TRFCAB_CYC (((`TRFCAB_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define BURST_MAX 8
`define TREFBW_CYC (4 * 8 * (`TRFCAB_CYC))
`define TRRD_NS 10
`define TRRD_CYC ((((`TRRD_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS)) > 0 ? \
   (((`TRRD_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS)) : 1)
`define TCKESR_NS 15
`define TCKESR_CYC (((`TCKESR_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define TXSR_NS 140
`define TXSR_CYC (((`TXSR_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define STABLE_CK_CYC 2
`define CLK_DIV 4
`define CA_REF_AB 10'h00c
`define CA_SREF 10'h004
`define CA_ACT 10'h000
`define CA_NOP 10'h007
`endif

// >>> rtl/lpddr2_ref_pkg.sv
// types for the refresh and self-refresh controller
package lpddr2_ref_pkg;
   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_REF     = 7'h02,
      ST_ACT     = 7'h04,
      ST_SR_IN   = 7'h08,
      ST_SR      = 7'h10,
      ST_SR_CK   = 7'h20,
      ST_SR_XIT  = 7'h40
   } ctl_state_t;
endpackage

// >>> rtl/ref_hist_if.sv
// link between the controller and its refresh history keeper
interface ref_hist_if;
   logic issue;
   logic [15:0] window_cnt;
   logic burst_ok;
   logic window_ok;
   modport ctl (output issue, input window_cnt, input burst_ok, input window_ok);
   modport hist (input issue, output window_cnt, output burst_ok, output window_ok);
endinterface

// >>> rtl/ref_history.sv
// rolling record of recent refresh issue times
`include "lpddr2_ref_cfg.svh"
module ref_history #(
   parameter int BURST_MAX = `BURST_MAX,
   parameter int TREFBW_CYC = `TREFBW_CYC,
   parameter int REQ = `REF_PER_WINDOW
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // history port
   ref_hist_if.hist h
);
   localparam int TW = 16;
   logic [TW-1:0] stamp [BURST_MAX];
   logic [BURST_MAX-1:0] live;
   logic [TW-1:0] now;
   logic [$clog2(BURST_MAX)-1:0] wp;
   logic [15:0] win;
   // slot ages out once its age reaches the burst window
   logic [BURST_MAX-1:0] young;
   genvar g;
   generate
      for (g = 0; g < BURST_MAX; g++) begin : g_age
         assign young[g] = live[g] && ((now - stamp[g]) < TW'(TREFBW_CYC));
      end
   endgenerate
   assign h.burst_ok = ~(&young);
   assign h.window_cnt = win;
   assign h.window_ok = (win >= 16'(REQ));
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         now <= 16'h0000;
         wp <= '0;
         live <= '0;
         win <= 16'h0000;
      end else begin
         now <= now + 16'h0001;
         if (h.issue) begin
            stamp[wp] <= now;
            live[wp] <= 1'b1;
            wp <= (int'(wp) == BURST_MAX - 1) ? '0 : wp + 1'b1;
            if (win != 16'hffff) win <= win + 16'h0001;
         end
      end
   end
endmodule

// >>> rtl/ck_divider.sv
// link clock divider, gated for self-refresh clock stop
`include "lpddr2_ref_cfg.svh"
module ck_divider #(
   parameter int DIV = `CLK_DIV
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   // link clock
   output logic ck_o,
   output logic rise_o
);
   logic [7:0] cnt;
   assign rise_o = run_i && (cnt == 8'(DIV / 2 - 1)) && !ck_o;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 8'h00;
         ck_o <= 1'b0;
      end else if (!run_i) begin
         cnt <= 8'h00;
         ck_o <= 1'b0;
      end else if (cnt == 8'(DIV / 2 - 1)) begin
         cnt <= 8'h00;
         ck_o <= ~ck_o;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// >>> rtl/lpddr2_ref_ctl.sv
// host-side refresh scheduler and self-refresh sequencer
`include "lpddr2_ref_cfg.svh"
module lpddr2_ref_ctl
   import lpddr2_ref_pkg::*;
#(
   parameter int TREFI_CYC = `TREFI_CYC,
   parameter int TRFCAB_CYC = `TRFCAB_CYC,
   parameter int TREFBW_CYC = `TREFBW_CYC,
   parameter int TRRD_CYC = `TRRD_CYC,
   parameter int TCKESR_CYC = `TCKESR_CYC,
   parameter int TXSR_CYC = `TXSR_CYC,
   parameter int CLK_DIV = `CLK_DIV,
   parameter int BURST_MAX = `BURST_MAX,
   parameter int REQ = `REF_PER_WINDOW
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // user requests
   input wire logic banks_idle_i,
   input wire logic act_req_i,
   input wire logic [2:0] act_bank_i,
   input wire logic burst_mode_i,
   input wire logic sr_enter_i,
   input wire logic sr_exit_i,
   output logic act_grant_o,
   output logic ref_busy_o,
   output logic in_sr_o,
   output logic ready_o,
   output logic [15:0] ref_count_o,
   // sdram pins
   output logic ck_o,
   output logic cke_o,
   output logic cs_n_o,
   output logic [9:0] ca_o
);
   ctl_state_t state, next_state;
   ref_hist_if hif ();
   logic ck_run, ck_rise;
   logic [15:0] tmr, next_tmr;
   logic [15:0] refi_cnt;
   logic [15:0] rrd_cnt;
   logic [15:0] owed;
   logic [2:0] last_bank;
   logic have_last;
   logic ref_since_sr;
   logic [15:0] sr_cnt;
   logic cmd_ref, cmd_sr, cmd_act;

   ref_history #(
      .BURST_MAX(BURST_MAX),
      .TREFBW_CYC(TREFBW_CYC),
      .REQ(REQ)
   ) u_hist (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .h(hif.hist)
   );

   ck_divider #(
      .DIV(CLK_DIV)
   ) u_ck (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .run_i(ck_run),
      .ck_o(ck_o),
      .rise_o(ck_rise)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decisions, all taken on link clock rising edges
   wire tmr_done = (tmr == 16'h0000);
   wire ref_due = (owed != 16'h0000) || (burst_mode_i && !hif.window_ok);
   wire rrd_ok = !have_last || (act_bank_i == last_bank) || (rrd_cnt == 16'h0000);
   wire can_ref = banks_idle_i && hif.burst_ok && tmr_done;
   wire can_act = tmr_done && rrd_ok && !ref_due;
   wire can_sr = banks_idle_i && ref_since_sr && tmr_done;

   assign cmd_ref = ck_rise && (state == ST_IDLE) && ref_due && can_ref;
   assign cmd_act = ck_rise && (state == ST_IDLE) && !cmd_ref && act_req_i && can_act;
   assign cmd_sr = ck_rise && (state == ST_IDLE) && !cmd_ref && !cmd_act && sr_enter_i && can_sr;
   assign hif.issue = cmd_ref;
   assign act_grant_o = cmd_act;
   assign ref_busy_o = (state == ST_REF);
   assign in_sr_o = (state == ST_SR) || (state == ST_SR_IN) || (state == ST_SR_CK);
   assign ready_o = (state == ST_IDLE) && tmr_done;
   assign ref_count_o = hif.window_cnt;
   // clock stopped only while resting in self-refresh
   assign ck_run = (state != ST_SR);

   ////////////////////////////////////////////////////////////////////////////
   // state sequencing
   always_comb begin
      next_state = state;
      next_tmr = tmr;
      if (ck_rise && !tmr_done) next_tmr = tmr - 16'h0001;
      case (state)
         ST_IDLE: begin
            if (cmd_ref) begin
               next_state = ST_REF;
               next_tmr = 16'(TRFCAB_CYC);
            end else if (cmd_act) begin
               next_state = ST_ACT;
            end else if (cmd_sr) begin
               next_state = ST_SR_IN;
               next_tmr = 16'(TCKESR_CYC);
            end
         end
         ST_REF: begin
            next_state = ST_IDLE;
         end
         ST_ACT: begin
            next_state = ST_IDLE;
         end
         ST_SR_IN: begin
            // nop cycle after entry before the clock may stop
            if (ck_rise) next_state = ST_SR;
         end
         ST_SR: begin
            // core clock keeps counting tCKESR while the link clock is stopped
            if (!tmr_done) next_tmr = tmr - 16'h0001;
            if (tmr_done && sr_exit_i) begin
               next_state = ST_SR_CK;
               next_tmr = 16'(`STABLE_CK_CYC);
            end
         end
         ST_SR_CK: begin
            if (ck_rise && tmr == 16'h0001) begin
               next_state = ST_SR_XIT;
               next_tmr = 16'(TXSR_CYC);
            end
         end
         ST_SR_XIT: begin
            if (tmr_done) next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         tmr <= 16'h0000;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // refresh debt: one owed per tREFI, cleared during self-refresh, or set to BURST_MAX in burst mode
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         refi_cnt <= 16'h0000;
         owed <= 16'h0001;
         sr_cnt <= 16'h0000;
      end else begin
         if (in_sr_o) begin
            // device refreshes itself; debt cleared, or held at BURST_MAX in burst mode
            if (refi_cnt == 16'(TREFI_CYC - 1)) refi_cnt <= 16'h0000;
            else refi_cnt <= refi_cnt + 16'h0001;
            sr_cnt <= sr_cnt + 16'h0001;
            if (burst_mode_i) owed <= 16'(BURST_MAX);
            else owed <= 16'h0000;
         end else if (refi_cnt == 16'(TREFI_CYC - 1)) begin
            refi_cnt <= 16'h0000;
            owed <= cmd_ref ? owed : owed + 16'h0001;
         end else begin
            refi_cnt <= refi_cnt + 16'h0001;
            if (cmd_ref && owed != 16'h0000) owed <= owed - 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rrd_cnt <= 16'h0000;
         last_bank <= 3'h0;
         have_last <= 1'b0;
         ref_since_sr <= 1'b1;
      end else begin
         if (cmd_act) begin
            rrd_cnt <= 16'(TRRD_CYC);
            last_bank <= act_bank_i;
            have_last <= 1'b1;
         end else if (ck_rise && rrd_cnt != 16'h0000) begin
            rrd_cnt <= rrd_cnt - 16'h0001;
         end
         if (cmd_sr) ref_since_sr <= 1'b0;
         else if (cmd_ref) ref_since_sr <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive; the device ignores all but cke while in self-refresh
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cke_o <= 1'b1;
         cs_n_o <= 1'b1;
         ca_o <= `CA_NOP;
      end else begin
         if (cmd_ref) begin
            cs_n_o <= 1'b0;
            ca_o <= `CA_REF_AB;
         end else if (cmd_act) begin
            cs_n_o <= 1'b0;
            ca_o <= {act_bank_i, 7'h00};
         end else if (cmd_sr) begin
            cs_n_o <= 1'b0;
            cke_o <= 1'b0;
            ca_o <= `CA_SREF;
         end else if (ck_rise) begin
            cs_n_o <= 1'b1;
            ca_o <= `CA_NOP;
         end
         if (state == ST_SR_CK && next_state == ST_SR_XIT) cke_o <= 1'b1;
      end
   end
endmodule

// >>> testbench/lpddr2_ref_checker.sv
// pin-level assertions for the refresh and self-refresh controller
module lpddr2_ref_checker #(
   parameter int TREFBW_CYC = 96,
   parameter int BURST_MAX = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // watched ports
   input wire logic banks_idle_i,
   input wire logic ref_busy_o,
   input wire logic ck_o,
   input wire logic cke_o,
   input wire logic cs_n_o,
   input wire logic [9:0] ca_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////
   wire ref_cmd = cke_o & ~cs_n_o & (ca_o[3:0] == 4'hc);
   logic [TREFBW_CYC-1:0] hist;
   logic [3:0] rises;
   logic refd;
   // one bit per issue edge, so a ninth refresh inside the window shows
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hist <= '0;
         rises <= 4'h0;
         refd <= 1'b1;
      end else begin
         hist <= {hist[TREFBW_CYC-2:0], ref_cmd & ref_busy_o};
         rises <= cke_o ? 4'h0 : rises + {3'h0, $rose(ck_o) && rises != 4'hf};
         refd <= ref_cmd | (refd & ~$rose(cke_o));
      end
   end
   ////////////////////////////////////////////////////////////
   sequence sr_cmd_s;
      !cs_n_o && ca_o[2:0] == 3'b100;
   endsequence
   sequence held_low_s;
      !cke_o [*8];
   endsequence
   sequence xsr_nop_s;
      cs_n_o [*8];
   endsequence
   sequence xsr_cke_s;
      cke_o [*8];
   endsequence
   chk_sr_code: assert property ($fell(cke_o) |-> sr_cmd_s)
      else $error("self-refresh entry code wrong");
   chk_sr_nop: assert property ($fell(cke_o) |-> ##[1:8] (cs_n_o && ca_o == 10'h007))
      else $error("no nop after self-refresh entry");
   chk_sr_held: assert property ($fell(cke_o) |-> held_low_s)
      else $error("cke not held low in self-refresh");
   chk_exit_clocks: assert property ($rose(cke_o) |-> rises >= 4'h2)
      else $error("cke raised without two clocks");
   chk_xsr_nop: assert property ($rose(cke_o) |-> xsr_nop_s)
      else $error("command inside exit interval");
   chk_xsr_cke: assert property ($rose(cke_o) |-> xsr_cke_s)
      else $error("cke dropped inside exit interval");
   chk_ref_first: assert property ($fell(cke_o) |-> refd)
      else $error("self-refresh without refresh since exit");
   chk_sr_idle: assert property ($fell(cke_o) |-> $past(banks_idle_i))
      else $error("self-refresh with busy banks");
   chk_ref_code: assert property ($rose(ref_busy_o) |-> ref_cmd)
      else $error("refresh busy without refresh code");
   chk_burst_max: assert property ($countones(hist) <= BURST_MAX)
      else $error("too many refreshes in window");
endmodule
bind lpddr2_ref_ctl lpddr2_ref_checker #(
   .TREFBW_CYC(TREFBW_CYC),
   .BURST_MAX(BURST_MAX)
) lpddr2_ref_checker_i (
   .core_clk_i(core_clk_i),
   .rst_i(rst_i),
   .banks_idle_i(banks_idle_i),
   .ref_busy_o(ref_busy_o),
   .ck_o(ck_o),
   .cke_o(cke_o),
   .cs_n_o(cs_n_o),
   .ca_o(ca_o)
);

// >>> testbench/lpddr2_dev_model.sv
// behavioural sdram die watching the controller's command pins
module lpddr2_dev_model (
   // sdram pins
   input wire logic ck_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic [9:0] ca_i,
   // bank status from the bench
   input wire logic banks_idle_i,
   // counts for the bench
   output int n_ref,
   output int n_self,
   output int n_bad
);
   timeunit 1ns;
   timeprecision 1ns;
   bit in_sr;
   bit owe;
   bit was_cke = 1'b1;
   int lows;
   realtime t_sr, t_xsr, t_ref, t_act;
   realtime refs[$];
   initial begin
      n_ref = 0;
      n_self = 0;
      n_bad = 0;
   end
   // looks 1 ns past the edge so pins launched with it are seen
   always @(posedge ck_i) begin
      #1;
      if (in_sr) begin
         // only cke is looked at, data kept by the internal timer
         if (!cke_i) lows++;
         else begin
            if (lows < 2 || $realtime - t_sr < 15.0) n_bad++;
            in_sr = 0;
            t_xsr = $realtime;
         end
      end else if (!cke_i && was_cke) begin
         if (cs_n_i || ca_i[2:0] != 3'b100 || owe || !banks_idle_i) n_bad++;
         in_sr = 1;
         owe = 1;
         lows = 0;
         t_sr = $realtime;
         fork
            #15 n_self++;
         join_none
      end else if (!cs_n_i) begin
         if ($realtime - t_xsr < 140.0 || !cke_i) n_bad++;
         if (ca_i[3:0] == 4'hc) begin
            if (!banks_idle_i) n_bad++;
            refs.push_back($realtime);
            while ($realtime - refs[0] >= 4160.0) refs.pop_front();
            if (refs.size() > 8) n_bad++;
            n_ref++;
            owe = 0;
            t_ref = $realtime;
         end else if (ca_i[6:0] == 7'h00) begin
            if ($realtime - t_ref < 130.0 || $realtime - t_act < 10.0) n_bad++;
            t_act = $realtime;
         end
      end
      was_cke = cke_i;
   end
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the refresh and self-refresh controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic banks_idle = 1'b1;
   logic act_req = 1'b0;
   logic [2:0] act_bank = 3'h0;
   logic burst_mode = 1'b0;
   logic sr_enter = 1'b0;
   logic sr_exit = 1'b0;
   logic act_grant, ref_busy, in_sr, ready, ck, cke, cs_n;
   logic [9:0] ca;
   logic [15:0] ref_count, r0, rs;
   int n_ref, n_self, n_bad;
   int n_sr = 0;
   int n_fail = 0;
   int n_compared = 0;
   always #25 core_clk_i = ~core_clk_i;
   ////////////////////////////////////////////////////////////
   // short refresh interval and small burst target keep the run brief
   lpddr2_ref_ctl #(.TREFI_CYC(20), .REQ(64)) lpddr2_ref_ctl_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .banks_idle_i(banks_idle), .act_req_i(act_req),
      .act_bank_i(act_bank), .burst_mode_i(burst_mode), .sr_enter_i(sr_enter), .sr_exit_i(sr_exit),
      .act_grant_o(act_grant), .ref_busy_o(ref_busy), .in_sr_o(in_sr), .ready_o(ready),
      .ref_count_o(ref_count), .ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca));
   lpddr2_dev_model lpddr2_dev_model_i (
      .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .ca_i(ca), .banks_idle_i(banks_idle),
      .n_ref(n_ref), .n_self(n_self), .n_bad(n_bad));
   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   task t_regular;
      r0 = ref_count;
      cycles(400);
      check("refreshes in 400 cycles", 16'h1, 16'(ref_count - r0 >= 16'h13));
      check("refresh codes at die", 16'h1, 16'(n_ref >= 19));
   endtask
   // back-to-back activates through all banks
   task t_act;
      act_req = 1'b1;
      for (int b = 0; b < 8; b++) begin
         act_bank = 3'(b);
         for (int i = 0; i < 100 && act_grant !== 1'b1; i++) cycles(1);
         cycles(1);
         check("activate pins", {13'h0, 3'(b)}, {12'h0, cs_n, ca[9:7]});
      end
      act_req = 1'b0;
      check("die faults", 16'h0, 16'(n_bad));
   endtask
   task t_burst;
      burst_mode = 1'b1;
      r0 = ref_count;
      cycles(960);
      check("burst limit", 16'h1, 16'(ref_count - r0 <= 16'h58));
      check("burst keeps count", 16'h1, 16'(ref_count - r0 >= 16'h2f));
   endtask
   task t_refused;
      banks_idle = 1'b0;
      sr_enter = 1'b1;
      r0 = ref_count;
      cycles(100);
      check("entry with busy banks", 16'h0, {15'h0, in_sr});
      check("refresh with busy banks", r0, ref_count);
      banks_idle = 1'b1;
   endtask
   task sr_cycle;
      sr_enter = 1'b1;
      // owed refreshes must drain first, at one per four link cycles
      for (int i = 0; i < 2000 && in_sr !== 1'b1; i++) cycles(1);
      rs = ref_count;
      sr_enter = 1'b0;
      n_sr++;
      cycles(40);
      r0 = {14'h0, ck, cke};
      cycles(2);
      check("clock and cke in self-refresh", 16'h0, r0 | {14'h0, ck, cke});
      check("internal refreshes", 16'(n_sr), 16'(n_self));
      sr_exit = 1'b1;
      for (int i = 0; i < 400 && (ready !== 1'b1 || in_sr !== 1'b0); i++) cycles(1);
      sr_exit = 1'b0;
      check("cke after exit", 16'h1, {15'h0, cke});
      check("die faults", 16'h0, 16'(n_bad));
   endtask
   task t_sr_again;
      r0 = ref_count;
      sr_cycle();
      check("refresh between entries", 16'h1, 16'(rs > r0));
      r0 = ref_count;
      cycles(200);
      check("burst after exit", 16'h1, 16'(ref_count - r0 >= 16'hc));
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      cycles(5);
      rst_i = 1'b0;
      t_regular();
      t_act();
      t_burst();
      t_refused();
      sr_cycle();
      t_sr_again();
      report_and_stop();
   end
   // far beyond the few thousand cycles the tests take
   initial begin
      #1000000;
      n_fail++;
      report_and_stop();
   end
endmodule
